// >>> rtl/qcb_pkg.sv
// Shared constants and types for the quad channel buffer.
package qcb_pkg;
    localparam int CHAN_N     = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [CHAN_N-1:0] DRV_LOW_P = 4'h0;
    localparam logic [CHAN_N-1:0] DRV_LOW_N = 4'hf;
    typedef enum logic [2:0] {
        QCB_OFF  = 3'h1,
        QCB_PASS = 3'h2,
        QCB_REG  = 3'h4
    } qcb_mode_t;
endpackage : qcb_pkg

// >>> rtl/qcb_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module qcb_fifo #(
    parameter int W     = 4,
    parameter int DEPTH = 16
) (
    // Clock, reset and flush.
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         flush,
    // Fill side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0]   count, next_count;
    logic          full, empty, next_full, next_empty;
    logic          push, pop;

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & ~full;
    assign pop       = ~empty & out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else begin
            if (push) begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (pop) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
            next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        end
        next_full  = (next_count == (AW+1)'(DEPTH));
        next_empty = (next_count == '0);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            full   <= 1'b0;
            empty  <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            full   <= next_full;
            empty  <= next_empty;
        end
    end

    // The storage has no reset; empty guards every read of it.
    always_ff @(posedge clock) begin
        if (push && !flush) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : qcb_fifo

// >>> rtl/qcb_buffer.sv
// Four channel buffer with pass-through and clocked capture modes.
`timescale 1ns/1ps
module qcb_buffer
    import qcb_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // System clock and reset.
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Differential controls.
    input  wire logic              gate_p,
    input  wire logic              gate_n,
    input  wire logic              mode_p,
    input  wire logic              mode_n,
    input  wire logic              lclk_p,
    input  wire logic              lclk_n,
    // Channel sources.
    input  wire logic [CHAN_N-1:0] src_p,
    input  wire logic [CHAN_N-1:0] src_n,
    // Channel drives.
    output logic [CHAN_N-1:0]      drv_p,
    output logic [CHAN_N-1:0]      drv_n,
    // Flow control.
    input  wire logic              sink_ready,
    output logic                   capture_ready
);
    // Every check below runs on the system clock and sleeps in reset.
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // ************************************************************
    // Input decode
    // ************************************************************
    // An undefined pair such as both legs equal reads as low.
    function automatic logic diff_high(input logic p, input logic n);
        diff_high = p & ~n;
    endfunction : diff_high

    logic              gate, mode, lclk, cur_reg, edge_rise, fifo_push;
    logic [CHAN_N-1:0] src;
    logic              fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [CHAN_N-1:0] fifo_out_data;

    assign gate = diff_high(gate_p, gate_n);
    assign mode = diff_high(mode_p, mode_n);
    assign lclk = diff_high(lclk_p, lclk_n);
    assign src  = src_p & ~src_n;

    // ************************************************************
    // Mode and capture
    // ************************************************************
    qcb_mode_t         state, next_state;
    logic              lclk_prev, next_lclk_prev;
    logic [CHAN_N-1:0] next_drv_p, next_drv_n;
    logic              next_capture_ready;

    assign cur_reg   = gate & ~mode;
    assign edge_rise = lclk & ~lclk_prev;
    assign fifo_push = edge_rise & cur_reg;
    assign fifo_pop  = cur_reg & sink_ready;

    qcb_fifo #(
        .W     (CHAN_N),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .flush     (~cur_reg),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (src),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        next_lclk_prev     = lclk;
        next_capture_ready = cur_reg & fifo_in_ready;
        next_drv_p         = drv_p;
        if (!gate) begin
            next_state = QCB_OFF;
        end else if (mode) begin
            next_state = QCB_PASS;
        end else begin
            next_state = QCB_REG;
        end
        case (next_state)
            QCB_OFF: begin
                next_drv_p = DRV_LOW_P;
            end
            QCB_PASS: begin
                next_drv_p = src;
            end
            QCB_REG: begin
                // Captured words queue here when the sink stalls.
                if (fifo_out_valid && sink_ready) begin
                    next_drv_p = fifo_out_data;
                end else begin
                    next_drv_p = drv_p;
                end
            end
            default: begin
                next_drv_p = DRV_LOW_P;
            end
        endcase
        next_drv_n = ~next_drv_p;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state         <= QCB_OFF;
            lclk_prev     <= 1'b0;
            drv_p         <= DRV_LOW_P;
            drv_n         <= DRV_LOW_N;
            capture_ready <= 1'b0;
        end else begin
            state         <= next_state;
            lclk_prev     <= next_lclk_prev;
            drv_p         <= next_drv_p;
            drv_n         <= next_drv_n;
            capture_ready <= next_capture_ready;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_edge_reg;
        cur_reg && lclk && !lclk_prev;
    endsequence

    sequence s_straight_through;
        s_edge_reg ##0 (!fifo_out_valid && sink_ready) ##1
            (cur_reg && sink_ready);
    endsequence

    sequence s_pop_reg;
        cur_reg && fifo_out_valid && sink_ready;
    endsequence

    chk_gate_low_out: assert property
        (!gate |=> (drv_p == DRV_LOW_P) && (drv_n == DRV_LOW_N))
        else $error("Outputs not low after gate went low.");

    chk_pair_comp: assert property
        (drv_n == ~drv_p)
        else $error("Output pair legs are not complementary.");

    chk_state_off: assert property
        (!gate |=> state == QCB_OFF)
        else $error("State not off after gate went low.");

    // The first low cycle may still show the last driven word, so the
    // stability test starts once the gate has been low for two cycles.
    chk_gate_no_push: assert property
        ((!gate ##1 !gate) |-> !fifo_push ##1 $stable(drv_p))
        else $error("Activity seen while gate is low.");

    chk_gate_flush: assert property
        (!gate |=> !fifo_out_valid)
        else $error("Queued captures survived a low gate.");

    chk_ready_idle: assert property
        (!cur_reg |=> !capture_ready)
        else $error("Capture ready high outside registered mode.");

    chk_pass_copy: assert property
        ((gate && mode) |=> drv_p == $past(src))
        else $error("Pass-through output differs from source.");

    chk_pass_leg_n: assert property
        ((gate && mode) |=> drv_n == ~$past(src))
        else $error("Pass-through inverting leg differs from source.");

    chk_state_pass: assert property
        ((gate && mode) |=> state == QCB_PASS)
        else $error("State not pass-through with mode high.");

    chk_pass_no_clk: assert property
        ((gate && mode) |-> !fifo_push ##1 !fifo_out_valid)
        else $error("Clock edge captured in pass-through mode.");

    chk_state_reg: assert property
        ((gate && !mode) |=> state == QCB_REG)
        else $error("State not registered with mode low.");

    chk_edge_capture: assert property
        ((s_edge_reg ##0 fifo_in_ready) |=> fifo_out_valid)
        else $error("Rising edge in registered mode not captured.");

    chk_edge_single: assert property
        ((cur_reg && lclk && lclk_prev) |-> !fifo_push)
        else $error("A steady high data clock captured again.");

    chk_ready_track: assert property
        (cur_reg |=> capture_ready == $past(fifo_in_ready))
        else $error("Capture ready does not follow queue room.");

    chk_edge_to_out: assert property
        (s_straight_through |=> drv_p == $past(src, 2))
        else $error("Captured value not on output two cycles after edge.");

    chk_reg_pop: assert property
        (s_pop_reg |=> drv_p == $past(fifo_out_data))
        else $error("Queue head not moved to the outputs.");

    chk_reg_hold: assert property
        ((cur_reg && !(fifo_out_valid && sink_ready)) |=> $stable(drv_p))
        else $error("Registered output changed without a new capture.");
endmodule : qcb_buffer

// >>> bench/qcb_far_model.sv
// Far side model: data clock source and downstream sink.
`timescale 1ns/1ps
module qcb_far_model (
    // Clock.
    input  wire logic clock,
    // Commands from the bench.
    input  wire logic fire,
    input  wire logic stall,
    // Toward the buffer.
    output logic      lclk_p,
    output logic      lclk_n,
    output logic      sink_ready
);
    // ****************************************
    // Clock pulse and sink.
    // ****************************************
    logic lvl = 1'b0;
    logic rdy = 1'b0;
    // The data clock rests low unless a pulse is asked for, so it stays
    // quiet until the bench sets fire and never reads as an edge at reset.
    always @(posedge clock) begin
        lvl <= fire;
        rdy <= ~stall;
    end
    assign lclk_p     = lvl;
    assign lclk_n     = ~lvl;
    assign sink_ready = rdy;
endmodule : qcb_far_model

// >>> bench/qcb_buffer_bench.sv
// Self-checking bench for the quad channel buffer.
`timescale 1ns/1ps
module qcb_buffer_bench
    import qcb_pkg::*;
;
    // ****************************************
    // Stimulus, far side and design.
    // ****************************************
    logic              clock = 1'b0;
    logic              rst_b = 1'b0;
    logic              gate  = 1'b0;
    logic              mode  = 1'b1;
    logic              fire  = 1'b0;
    logic              stall = 1'b0;
    logic [CHAN_N-1:0] word  = 4'h0;
    logic              lclk_p, lclk_n, sink_ready, capture_ready;
    logic [CHAN_N-1:0] drv_p, drv_n;
    int                err_total = 0;
    int                compares  = 0;
    always #20 clock = ~clock;
    qcb_far_model far (.clock(clock), .fire(fire), .stall(stall),
        .lclk_p(lclk_p), .lclk_n(lclk_n), .sink_ready(sink_ready));
    qcb_buffer #(.DEPTH(FIFO_DEPTH)) dut (.clock(clock), .rst_b(rst_b),
        .gate_p(gate), .gate_n(~gate), .mode_p(mode), .mode_n(~mode),
        .lclk_p(lclk_p), .lclk_n(lclk_n), .src_p(word), .src_n(~word),
        .drv_p(drv_p), .drv_n(drv_n), .sink_ready(sink_ready),
        .capture_ready(capture_ready));
    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic chk4(string what, logic [3:0] e, logic [3:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk4
    task automatic chk1(string what, logic e, logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : chk1
    task automatic edges(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : edges
    task automatic chk_drv(logic [3:0] e);
        chk4("drv_p", e, drv_p);
        chk4("drv_n", ~e, drv_n);
    endtask : chk_drv
    // A pop can land a cycle or two late, so the wait is bounded.
    task automatic wait_drv(logic [3:0] e);
        for (int i = 0; i < 8 && drv_p !== e; i++) edges(1);
        chk_drv(e);
    endtask : wait_drv
    task automatic capture(logic [3:0] w);
        @(posedge clock) begin
            fire <= 1'b1;
            word <= w;
        end
        @(posedge clock) fire <= 1'b0;
        edges(1);
    endtask : capture
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic test_pass();
        @(posedge clock) begin
            gate <= 1'b1;
            word <= 4'ha;
        end
        edges(2);
        chk_drv(4'ha);
        capture(4'h5);
        chk_drv(4'h5);
    endtask : test_pass
    task automatic test_gate();
        @(posedge clock) gate <= 1'b0;
        edges(2);
        chk_drv(4'h0);
        @(posedge clock) mode <= 1'b0;
        capture(4'h9);
        capture(4'hc);
        @(posedge clock) begin
            mode <= 1'b1;
            word <= 4'h3;
        end
        edges(2);
        chk_drv(4'h0);
        @(posedge clock) gate <= 1'b1;
        edges(2);
        chk_drv(4'h3);
    endtask : test_gate
    task automatic test_reg();
        @(posedge clock) mode <= 1'b0;
        edges(2);
        chk1("capture_ready", 1'b1, capture_ready);
        capture(4'h7);
        wait_drv(4'h7);
        @(posedge clock) word <= 4'h2;
        edges(4);
        chk_drv(4'h7);
    endtask : test_reg
    task automatic test_fifo();
        @(posedge clock) stall <= 1'b1;
        edges(2);
        for (int i = 0; i < FIFO_DEPTH; i++) capture(4'(i + 4));
        edges(2);
        chk1("capture_ready", 1'b0, capture_ready);
        chk_drv(4'h7);
        capture(4'h4);
        @(posedge clock) stall <= 1'b0;
        #1;
        for (int i = 0; i < FIFO_DEPTH; i++) wait_drv(4'(i + 4));
        edges(4);
        chk_drv(4'h3);
    endtask : test_fifo
    task automatic finish_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // ****************************************
    // Main sequence and watchdog.
    // ****************************************
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        test_pass();
        test_gate();
        test_reg();
        test_fifo();
        finish_test();
    end
    // The whole run needs about 120 cycles; this leaves ample slack.
    initial begin
        repeat (2000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule : qcb_buffer_bench
